// file: include/bswt_pkg.sv
// Package with register map, field layout, reset values and timing for the stopwatch timer.
package bswt_pkg;
  // ==========================================================================
  // Register indices (byte address = 4 * index) and bus widths.
  localparam int unsigned APB_ADDR_W  = 18;
  localparam logic [15:0] IDX_CTRL    = 16'hff7c;
  localparam logic [15:0] IDX_HUND    = 16'hff7d;
  localparam logic [15:0] IDX_TENTH   = 16'hff7e;
  localparam logic [15:0] IDX_IRQ_EN  = 16'hffe7;
  localparam logic [15:0] IDX_FLAGS   = 16'hfff7;
  // ==========================================================================
  // Field positions.
  localparam int unsigned CTRL_RUN_BIT   = 0;
  localparam int unsigned CTRL_CLEAR_BIT = 1;
  localparam int unsigned SRC_TEN_HZ     = 0;
  localparam int unsigned SRC_ONE_HZ     = 1;
  // ==========================================================================
  // Reset values.
  localparam logic       RUN_RST    = 1'h0;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;
  localparam logic [1:0] FLAGS_RST  = 2'h0;
  localparam logic [3:0] DIGIT_RST  = 4'h0;
  // ==========================================================================
  // Timing: the divider tap runs at 256 Hz from a 20 MHz clock.
  localparam int unsigned CLK_HZ      = 20000000;
  localparam int unsigned TAP_HZ      = 256;
  localparam int unsigned TAP_CYC     = CLK_HZ / TAP_HZ;
  // Fractional stepper: 100 steps spread over 256 taps gives 2 or 3 taps per step.
  localparam logic [8:0]  STEP_ADD    = 9'h064;
  localparam logic [8:0]  STEP_MOD    = 9'h100;
  localparam logic [3:0]  DIGIT_MAX   = 4'h9;
  // ==========================================================================
  // The two BCD digits travel together.
  typedef struct packed {
    logic [3:0] tenths;
    logic [3:0] hundredths;
  } bswt_digits_t;
endpackage

// file: design/bswt_top.sv
// Two-digit BCD stopwatch timer with APB register access and interrupt flags.
`timescale 1ns/1ns
module bswt_top #(
  parameter int unsigned TAP_DIV = bswt_pkg::TAP_CYC
) (
  input  wire logic                            CLK_I,
  input  wire logic                            RST_N_I,
  input  wire logic                            PSEL_I,
  input  wire logic                            PENABLE_I,
  input  wire logic                            PWRITE_I,
  input  wire logic [bswt_pkg::APB_ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]                     PWDATA_I,
  input  wire logic [3:0]                      PSTRB_I,
  output logic      [31:0]                     PRDATA_O,
  output logic                                 PREADY_O,
  output logic                                 PSLVERR_O,
  output logic                                 IRQ_O,
  output logic                                 IRQ_TEN_HZ_O,
  output logic                                 IRQ_ONE_HZ_O
);

  // ==========================================================================
  // State.
  logic [31:0]                 tap_cnt_ff;
  logic                        tap_ff;
  logic [8:0]                  acc_ff;
  bswt_pkg::bswt_digits_t      digits_ff;
  logic                        run_ff;
  logic [3:0]                  irq_en_ff;
  logic [1:0]                  flags_ff;
  logic [31:0]                 prdata_ff;
  logic                        pready_ff;
  logic                        pslverr_ff;
  logic                        irq_ff;
  logic [1:0]                  irq_src_ff;

  // ==========================================================================
  // Address decode. The printed offsets are indices, so the word index sits above bit 1.
  function automatic logic hit(input logic [bswt_pkg::APB_ADDR_W-1:0] addr, input logic [15:0] idx);
    hit = (addr[bswt_pkg::APB_ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  wire        sel_ctrl  = hit(PADDR_I, bswt_pkg::IDX_CTRL);
  wire        sel_hund  = hit(PADDR_I, bswt_pkg::IDX_HUND);
  wire        sel_tenth = hit(PADDR_I, bswt_pkg::IDX_TENTH);
  wire        sel_en    = hit(PADDR_I, bswt_pkg::IDX_IRQ_EN);
  wire        sel_flags = hit(PADDR_I, bswt_pkg::IDX_FLAGS);
  wire        mapped    = sel_ctrl | sel_hund | sel_tenth | sel_en | sel_flags;
  wire        setup     = PSEL_I & ~PENABLE_I;
  // The slave always answers in the first access cycle, so a write lands there.
  wire        wr_acc    = PSEL_I & PENABLE_I & pready_ff & PWRITE_I & PSTRB_I[0] & mapped;
  wire        wr_ctrl   = wr_acc & sel_ctrl;
  wire        wr_en     = wr_acc & sel_en;
  wire        wr_flags  = wr_acc & sel_flags;

  // ==========================================================================
  // Read data selection. The clear strobe and unused flag bits read as zero.
  wire [3:0]  rd_ctrl   = {3'h0, run_ff};
  wire [3:0]  rd_flags  = {2'h0, flags_ff};
  wire [3:0]  rd_nib    = sel_ctrl  ? rd_ctrl :
                          sel_hund  ? digits_ff.hundredths :
                          sel_tenth ? digits_ff.tenths :
                          sel_en    ? irq_en_ff :
                          sel_flags ? rd_flags : 4'h0;
  wire [31:0] nxt_prdata = (setup & ~PWRITE_I) ? {28'h0, rd_nib} : 32'h0;

  // ==========================================================================
  // APB answer: ready, and error for an unmapped address, are raised for exactly the first access cycle.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      prdata_ff  <= 32'h0;
      pready_ff  <= 1'h0;
      pslverr_ff <= 1'h0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
    end
  end

  // ==========================================================================
  // Free-running 256 Hz tap. It keeps running while stopped so the phase is kept,
  // which is why a stop of any length only drops the taps that fall while stopped.
  wire        tap_wrap  = (tap_cnt_ff == TAP_DIV - 1);
  wire [31:0] nxt_tap_cnt = tap_wrap ? 32'h0 : tap_cnt_ff + 32'h1;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tap_cnt_ff <= 32'h0;
      tap_ff     <= 1'h0;
    end else begin
      tap_cnt_ff <= nxt_tap_cnt;
      tap_ff     <= tap_wrap;
    end
  end

  // ==========================================================================
  // Fractional stepper: adding 100 per tap and wrapping at 256 steps the
  // hundredths every 2 or 3 taps, giving decades of 25 or 26 taps in 4 : 6.
  wire        clear_req = wr_ctrl & PWDATA_I[bswt_pkg::CTRL_CLEAR_BIT];
  wire        run_now   = run_ff;
  wire        tap_run   = tap_ff & run_now;
  wire [8:0]  acc_sum   = acc_ff + bswt_pkg::STEP_ADD;
  wire        step      = tap_run & (acc_sum >= bswt_pkg::STEP_MOD);
  wire [8:0]  acc_adv   = step ? acc_sum - bswt_pkg::STEP_MOD : acc_sum;
  wire [8:0]  nxt_acc   = clear_req ? 9'h0 : (tap_run ? acc_adv : acc_ff);

  // Digit chain: the hundredths carry clocks the tenths.
  wire        hund_wrap  = step & (digits_ff.hundredths == bswt_pkg::DIGIT_MAX);
  wire        tenth_wrap = hund_wrap & (digits_ff.tenths == bswt_pkg::DIGIT_MAX);
  bswt_pkg::bswt_digits_t nxt_digits;
  assign nxt_digits.hundredths = clear_req ? bswt_pkg::DIGIT_RST :
                                 hund_wrap ? bswt_pkg::DIGIT_RST :
                                 step      ? digits_ff.hundredths + 4'h1 : digits_ff.hundredths;
  assign nxt_digits.tenths     = clear_req  ? bswt_pkg::DIGIT_RST :
                                 tenth_wrap ? bswt_pkg::DIGIT_RST :
                                 hund_wrap  ? digits_ff.tenths + 4'h1 : digits_ff.tenths;

  // Run control follows software writes only; a clear does not touch it.
  wire        nxt_run   = wr_ctrl ? PWDATA_I[bswt_pkg::CTRL_RUN_BIT] : run_ff;

  // ==========================================================================
  // Counter and stepper registers. A clear in the same cycle as a step wins.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      acc_ff    <= 9'h0;
      digits_ff <= {bswt_pkg::DIGIT_RST, bswt_pkg::DIGIT_RST};
      run_ff    <= bswt_pkg::RUN_RST;
    end else begin
      acc_ff    <= nxt_acc;
      digits_ff <= nxt_digits;
      run_ff    <= nxt_run;
    end
  end

  // ==========================================================================
  // Interrupt flags: overflow sets, a write of one clears, and set beats clear
  // so an overflow landing on the clearing write is never lost.
  wire [1:0]  flag_set  = {tenth_wrap, hund_wrap};
  wire [1:0]  flag_clr  = wr_flags ? PWDATA_I[1:0] : 2'h0;
  wire [1:0]  nxt_flags = flag_set | (flags_ff & ~flag_clr);
  wire [3:0]  nxt_irq_en = wr_en ? PWDATA_I[3:0] : irq_en_ff;
  wire [1:0]  nxt_irq_src = nxt_flags & nxt_irq_en[1:0];

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      flags_ff   <= bswt_pkg::FLAGS_RST;
      irq_en_ff  <= bswt_pkg::IRQ_EN_RST;
      irq_src_ff <= 2'h0;
      irq_ff     <= 1'h0;
    end else begin
      flags_ff   <= nxt_flags;
      irq_en_ff  <= nxt_irq_en;
      irq_src_ff <= nxt_irq_src;
      irq_ff     <= |nxt_irq_src;
    end
  end

  // ==========================================================================
  // Outputs, each straight from a flip-flop.
  assign PRDATA_O     = prdata_ff;
  assign PREADY_O     = pready_ff;
  assign PSLVERR_O    = pslverr_ff;
  assign IRQ_O        = irq_ff;
  assign IRQ_TEN_HZ_O = irq_src_ff[bswt_pkg::SRC_TEN_HZ];
  assign IRQ_ONE_HZ_O = irq_src_ff[bswt_pkg::SRC_ONE_HZ];

  // ==========================================================================
  // Checker helpers: taps counted since the last hundredths step, since the
  // last hundredths wrap and since the last tenths wrap. They only feed the
  // assertions below. A clear restarts all three together with the stepper,
  // so the gaps checked below are exact rather than approximate.
  logic [2:0] gap_step_ff;
  logic [4:0] gap_dec_ff;
  logic [8:0] gap_sec_ff;

  // Each counter saturates, so a stuck stepper shows up as a wrong gap
  // instead of silently wrapping back into the legal range.
  wire [2:0]  nxt_gap_step = clear_req ? 3'h0 :
                             step      ? 3'h0 :
                             (tap_run && gap_step_ff != 3'h7) ? gap_step_ff + 3'h1 : gap_step_ff;
  wire [4:0]  nxt_gap_dec  = clear_req ? 5'h00 :
                             hund_wrap ? 5'h00 :
                             (tap_run && gap_dec_ff != 5'h1f) ? gap_dec_ff + 5'h01 : gap_dec_ff;
  wire [8:0]  nxt_gap_sec  = clear_req  ? 9'h000 :
                             tenth_wrap ? 9'h000 :
                             (tap_run && gap_sec_ff != 9'h1ff) ? gap_sec_ff + 9'h001 : gap_sec_ff;

  // Helper registers restart on reset like the stepper they shadow.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      gap_step_ff <= 3'h0;
      gap_dec_ff  <= 5'h00;
      gap_sec_ff  <= 9'h000;
    end else begin
      gap_step_ff <= nxt_gap_step;
      gap_dec_ff  <= nxt_gap_dec;
      gap_sec_ff  <= nxt_gap_sec;
    end
  end

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  AST_TEN_FLAG_SET: assert property (
    hund_wrap |=> flags_ff[bswt_pkg::SRC_TEN_HZ] && digits_ff.hundredths == 4'h0 || $past(clear_req))
    else $error("Hundredths wrap did not set the ten hertz flag.");

  AST_ONE_FLAG_SET: assert property (
    tenth_wrap |=> flags_ff[bswt_pkg::SRC_ONE_HZ])
    else $error("Tenths wrap did not set the one hertz flag.");

  AST_FLAG_W1C: assert property (
    wr_flags && PWDATA_I[0] && !hund_wrap |=> !flags_ff[0])
    else $error("Write of one failed to clear the ten hertz flag.");

  AST_FLAG_KEEP: assert property (
    flags_ff[1] && !(wr_flags && PWDATA_I[1]) |=> flags_ff[1])
    else $error("One hertz flag dropped without a clearing write.");

  AST_IRQ_LINES: assert property (
    ##1 {IRQ_ONE_HZ_O, IRQ_TEN_HZ_O} == (flags_ff & irq_en_ff[1:0]) && IRQ_O == |(flags_ff & irq_en_ff[1:0]))
    else $error("Interrupt lines disagree with flags and enables.");

  AST_STOP_HOLD: assert property (
    !run_ff && !clear_req |=> $stable(digits_ff))
    else $error("Digits changed while stopped.");

  AST_CLEAR_ZERO: assert property (
    clear_req |=> digits_ff == 8'h00 && acc_ff == 9'h0)
    else $error("Clear strobe did not zero the counter.");

  AST_CTRL_READ: assert property (
    setup && !PWRITE_I && sel_ctrl |=> PREADY_O && PRDATA_O == {31'h0, run_ff})
    else $error("Control read returned a set clear strobe.");

  AST_BCD_RANGE: assert property (
    digits_ff.hundredths <= 4'h9 && digits_ff.tenths <= 4'h9)
    else $error("Digit left the BCD range.");

  // Steps come after two or three taps, so one or two quiet taps precede each.
  AST_STEP_GAP: assert property (
    step |-> gap_step_ff == 3'h1 || gap_step_ff == 3'h2)
    else $error("Hundredths step gap was not two or three taps.");

  // A decade of hundredths lasts 25 or 26 taps.
  AST_DECADE_LEN: assert property (
    hund_wrap && !clear_req |-> gap_dec_ff == 5'h18 || gap_dec_ff == 5'h19)
    else $error("Hundredths decade was not 25 or 26 taps long.");

  // The tenths overflow comes after exactly 256 taps, once per second.
  AST_SECOND_LEN: assert property (
    tenth_wrap && !clear_req |-> gap_sec_ff == 9'h0ff)
    else $error("Tenths overflow was not one second after the last.");

  AST_TENTH_ON_CARRY: assert property (
    !hund_wrap && !clear_req |=> $stable(digits_ff.tenths))
    else $error("Tenths digit moved without a hundredths carry.");

  AST_HUND_STEP: assert property (
    step && !clear_req && !hund_wrap |=> digits_ff.hundredths == $past(digits_ff.hundredths) + 4'h1)
    else $error("Hundredths step did not add one.");

  AST_TEN_FLAG_KEEP: assert property (
    flags_ff[0] && !(wr_flags && PWDATA_I[0]) |=> flags_ff[0])
    else $error("Ten hertz flag dropped without a clearing write.");

  AST_FLAG_NO_SPURIOUS: assert property (
    !flags_ff[0] && !hund_wrap |=> !flags_ff[0])
    else $error("Ten hertz flag rose without a wrap.");

  AST_EN_HOLD: assert property (
    !wr_en |=> $stable(irq_en_ff))
    else $error("Enable register changed without a write.");

  AST_RUN_WRITE: assert property (
    wr_ctrl |=> run_ff == $past(PWDATA_I[0]))
    else $error("Run bit did not follow the control write.");

  AST_DIGIT_RO: assert property (
    wr_acc && (sel_hund || sel_tenth) && !step && !clear_req |=> $stable(digits_ff))
    else $error("Write to a digit register changed the digits.");

  AST_FLAGS_UPPER: assert property (
    setup && !PWRITE_I && sel_flags |=> PRDATA_O[31:2] == 30'h0)
    else $error("Unused flag bits did not read as zero.");

  AST_RD_IDLE_ZERO: assert property (
    !PREADY_O |-> PRDATA_O == 32'h0)
    else $error("Read data not zero outside the answer cycle.");

  AST_UNMAPPED_ERR: assert property (
    setup && !mapped |=> PSLVERR_O && PRDATA_O == 32'h0)
    else $error("Unmapped access was not refused.");

  AST_APB_ONE_WAIT: assert property (
    setup |=> PREADY_O ##1 !PREADY_O)
    else $error("APB ready did not last exactly one cycle.");

  COV_TEN_WRAP:   cover property (hund_wrap);
  COV_ONE_WRAP:   cover property (tenth_wrap);
  COV_SET_CLEAR:  cover property (hund_wrap && wr_flags && PWDATA_I[0]);
  COV_CLEAR_RUN:  cover property (clear_req && run_ff);
  COV_STOP_TAP:   cover property (!run_ff && tap_ff);

endmodule // bswt_top

// file: verification/tb.sv
// Self-checking testbench for the stopwatch timer: APB tasks and scenario sequences.
`timescale 1ns/1ns
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        irq_ten;
  logic        irq_one;
  logic [31:0] v1;
  logic [31:0] v2;
  logic        err;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  // ==========================================================================
  // Clock, reset and a short tap divider so that one second is 1024 cycles.
  always #25 clk = ~clk;
  bswt_top #(.TAP_DIV(4)) dut (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq), .IRQ_TEN_HZ_O(irq_ten), .IRQ_ONE_HZ_O(irq_one));
  // ==========================================================================
  // Verdict and closing; also reached when the cycle ceiling runs out.
  task automatic results();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // A hang must not run forever; the scenarios need about 1700 cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc >= 10000) begin
      fail_count++;
      results();
    end
  end
  // One comparison of a result against its expected value.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; entered just after a rising edge, returns one idle cycle later.
  // Data and error are taken at the rising edge at which ready is sampled high.
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, idx, d, r);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, idx, 32'h00000000, r);
    chk(r, exp);
  endtask
  // ==========================================================================
  // Scenario sequence.
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values of every register and the request lines.
    rd(bswt_pkg::IDX_CTRL, 32'h0);
    rd(bswt_pkg::IDX_HUND, 32'h0);
    rd(bswt_pkg::IDX_TENTH, 32'h0);
    rd(bswt_pkg::IDX_IRQ_EN, 32'h0);
    rd(bswt_pkg::IDX_FLAGS, 32'h0);
    chk({29'h0, irq, irq_ten, irq_one}, 32'h0);
    $display("test reset values done");
    // Access kinds: spare storage, read-only digits, write-only strobe, unmapped place.
    wr(bswt_pkg::IDX_IRQ_EN, 32'hf);
    rd(bswt_pkg::IDX_IRQ_EN, 32'hf);
    chk({31'h0, irq}, 32'h0);
    wr(bswt_pkg::IDX_IRQ_EN, 32'h0);
    wr(bswt_pkg::IDX_HUND, 32'h5);
    rd(bswt_pkg::IDX_HUND, 32'h0);
    wr(bswt_pkg::IDX_CTRL, 32'h2);
    rd(bswt_pkg::IDX_CTRL, 32'h0);
    rd(16'h0000, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test access kinds done");
    // Clear and run together, then one second of counting with both sources masked.
    wr(bswt_pkg::IDX_CTRL, 32'h3);
    repeat (990) @(posedge clk);
    rd(bswt_pkg::IDX_FLAGS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    repeat (60) @(posedge clk);
    rd(bswt_pkg::IDX_FLAGS, 32'h3);
    rd(bswt_pkg::IDX_CTRL, 32'h1);
    wr(bswt_pkg::IDX_CTRL, 32'h0);
    apb(1'b0, bswt_pkg::IDX_HUND, 32'h0, v1);
    repeat (200) @(posedge clk);
    apb(1'b0, bswt_pkg::IDX_HUND, 32'h0, v2);
    chk(v2, v1);
    $display("test counting done");
    // Unmasking raises each line; a flag left set keeps requesting; write-one clears.
    wr(bswt_pkg::IDX_IRQ_EN, 32'h3);
    repeat (100) @(posedge clk);
    chk({29'h0, irq, irq_ten, irq_one}, 32'h7);
    wr(bswt_pkg::IDX_FLAGS, 32'h0);
    rd(bswt_pkg::IDX_FLAGS, 32'h3);
    wr(bswt_pkg::IDX_FLAGS, 32'h1);
    rd(bswt_pkg::IDX_FLAGS, 32'h2);
    chk({29'h0, irq, irq_ten, irq_one}, 32'h5);
    wr(bswt_pkg::IDX_FLAGS, 32'h2);
    chk({29'h0, irq, irq_ten, irq_one}, 32'h0);
    wr(bswt_pkg::IDX_IRQ_EN, 32'h0);
    $display("test interrupts done");
    // Clear while stopped holds zero; clear while running restarts from zero.
    wr(bswt_pkg::IDX_CTRL, 32'h2);
    repeat (100) @(posedge clk);
    rd(bswt_pkg::IDX_HUND, 32'h0);
    rd(bswt_pkg::IDX_TENTH, 32'h0);
    wr(bswt_pkg::IDX_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    wr(bswt_pkg::IDX_CTRL, 32'h0);
    apb(1'b0, bswt_pkg::IDX_HUND, 32'h0, v1);
    chk({31'h0, v1 != 32'h0}, 32'h1);
    wr(bswt_pkg::IDX_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    wr(bswt_pkg::IDX_CTRL, 32'h3);
    wr(bswt_pkg::IDX_CTRL, 32'h0);
    rd(bswt_pkg::IDX_HUND, 32'h0);
    $display("test clear strobe done");
    results();
  end
endmodule // tb
